// File: bench/bus_read_master_bench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin \
  n_mismatch++; $display("MISMATCH %0t got %0h want %0h", $time, (g), (e)); end end
module bus_read_master_bench;
  logic mclk_i, rst_b_i, req_valid_i, req_byte_i, rd_ready_i, slow_mode;
  logic [23:0] req_addr_i;
  logic [2:0] req_space_i, cur_space;
  logic [7:0] ack_wait;
  logic req_ready_o, rd_valid_o, rd_autovec_o, word_address_oe_o;
  logic [15:0] rd_data_o, data_lines_i;
  logic [22:0] word_address_o;
  logic space_code_bit0_o, space_code_bit1_o, space_code_bit2_o;
  logic space_code_oe_o, rd_wr_n_o, rd_wr_oe_o, addr_strobe_n_o;
  logic addr_strobe_oe_o, upper_byte_strobe_n_o, upper_byte_strobe_oe_o;
  logic lower_byte_strobe_n_o, lower_byte_strobe_oe_o, xfer_ack_n_i;
  logic slow_periph_select_in_n_i, mem_addr_valid_out_n_o;
  logic mem_addr_valid_out_oe_o, periph_enable_o;
  logic [2:0] sc, strb;
  logic [6:0] oe_pins;
  int n_mismatch = 0, compares = 0, cycles = 0, vma_cnt = 0, en_ph = 0;

  bus_read_master bus_read_master_inst (.mclk_i, .rst_b_i, .req_valid_i,
    .req_ready_o, .req_addr_i, .req_space_i, .req_byte_i, .rd_valid_o,
    .rd_ready_i, .rd_data_o, .rd_autovec_o, .word_address_o,
    .word_address_oe_o, .data_lines_i, .space_code_bit0_o,
    .space_code_bit1_o, .space_code_bit2_o, .space_code_oe_o, .rd_wr_n_o,
    .rd_wr_oe_o, .addr_strobe_n_o, .addr_strobe_oe_o, .upper_byte_strobe_n_o,
    .upper_byte_strobe_oe_o, .lower_byte_strobe_n_o, .lower_byte_strobe_oe_o,
    .xfer_ack_n_i, .slow_periph_select_in_n_i, .mem_addr_valid_out_n_o,
    .mem_addr_valid_out_oe_o, .periph_enable_o);
  bus_slave_model bus_slave_model_inst (.mclk_i, .rst_b_i,
    .word_address_i(word_address_o), .addr_strobe_n_i(addr_strobe_n_o),
    .upper_byte_strobe_n_i(upper_byte_strobe_n_o),
    .lower_byte_strobe_n_i(lower_byte_strobe_n_o), .ack_wait_i(ack_wait),
    .slow_mode_i(slow_mode), .data_lines_o(data_lines_i),
    .xfer_ack_n_o(xfer_ack_n_i),
    .slow_periph_select_in_n_o(slow_periph_select_in_n_i));

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  assign sc = {space_code_bit2_o, space_code_bit1_o, space_code_bit0_o};
  assign strb = {addr_strobe_n_o, upper_byte_strobe_n_o,
    lower_byte_strobe_n_o};
  assign oe_pins = {space_code_oe_o, rd_wr_oe_o, word_address_oe_o,
    addr_strobe_oe_o, upper_byte_strobe_oe_o, lower_byte_strobe_oe_o,
    mem_addr_valid_out_oe_o};

  // pin watch at the falling edge, where outputs have settled
  always @(negedge mclk_i) begin
    if (rst_b_i === 1'b1 && addr_strobe_n_o === 1'b0) begin
      `CHK(sc, cur_space)
      `CHK({rd_wr_n_o, oe_pins}, 8'hFF)
    end
    // enable runs free from reset: low phase first, then high phase
    `CHK(periph_enable_o, en_ph >= rdbus_pkg::E_LOW_CYC)
    if (space_code_oe_o === 1'b1)
      `CHK(sc == 3'h0 || sc == 3'h3 || sc == 3'h4, 1'b0)
    if (mem_addr_valid_out_n_o === 1'b0) begin
      `CHK(slow_periph_select_in_n_i, 1'b0)
      vma_cnt++;
    end
  end

  // a hang is cut short well past the expected run length
  always @(posedge mclk_i) begin
    cycles++;
    en_ph = (rst_b_i !== 1'b1) ? 0 : (en_ph + 1) % rdbus_pkg::E_PERIOD_CYC;
    if (cycles == 5000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic conclude();
    if (n_mismatch == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  function automatic logic [15:0] word_of(input logic [23:0] a);
    return {a[8:1] ^ 8'h3C, a[16:9]};
  endfunction : word_of

  // hold the request until it is taken at a rising edge
  task automatic issue(input logic [23:0] a, input logic [2:0] sp,
      input logic b);
    logic r;
    int g;
    g = 0;
    @(posedge mclk_i);
    req_valid_i <= 1'b1;
    req_addr_i <= a;
    req_space_i <= sp;
    req_byte_i <= b;
    cur_space = sp;
    do begin
      #1 r = req_ready_o;
      @(posedge mclk_i);
      g++;
    end while (r !== 1'b1 && g < 200);
    req_valid_i <= 1'b0;
  endtask : issue

  // one read, walked state by state against the expected pin pattern
  task automatic walk(input logic [23:0] a, input logic [2:0] sp,
      input logic b, input int lat);
    int n;
    logic ue, le;
    logic [15:0] w, e;
    w = word_of(a);
    ue = b & a[0];
    le = b & !a[0];
    e = !b ? w : (a[0] ? {8'h00, w[7:0]} : {8'h00, w[15:8]});
    issue(a, sp, b);
    // the take edge has just passed, so state 0 stands now
    #1 `CHK({word_address_oe_o, space_code_oe_o}, 2'h1)
    `CHK({rd_wr_n_o, rd_wr_oe_o, strb}, 5'h1F)
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
      #1;
      if (n == 1) `CHK({word_address_oe_o, strb[2]}, 2'h3)
      if (n >= 2 && n <= 4) begin
        `CHK(strb, {1'b0, ue, le})
      end
      if (n == lat - 2) begin
        `CHK(strb, 3'h7)
        `CHK({word_address_oe_o, space_code_oe_o, rd_wr_n_o}, 3'h7)
      end
    end while (rd_valid_o !== 1'b1 && n < 40);
    `CHK(n, lat)
    `CHK({rd_autovec_o, rd_data_o}, {1'b0, e})
  endtask : walk

  // slow peripheral transfer timed by the enable instead of the ack
  task automatic slow(input logic [2:0] sp, input logic [16:0] e);
    int n;
    vma_cnt = 0;
    issue(24'h012346, sp, 1'b0);
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
      #1;
    end while (rd_valid_o !== 1'b1 && n < 200);
    `CHK({rd_autovec_o, rd_data_o}, e)
    `CHK(vma_cnt, 20)
  endtask : slow

  // reserved codes are held off, no bus cycle starts
  task automatic reserved();
    logic [2:0] codes [3] = '{3'h0, 3'h3, 3'h4};
    foreach (codes[i]) begin
      @(posedge mclk_i);
      req_valid_i <= 1'b1;
      req_space_i <= codes[i];
      repeat (6) begin
        #1 `CHK({req_ready_o, addr_strobe_oe_o}, 2'h0)
        @(posedge mclk_i);
      end
    end
    req_valid_i <= 1'b0;
  endtask : reserved

  // fill the result buffer while stalled, then drain it in order
  task automatic fill_drain();
    int taken, idle, i;
    logic r;
    taken = 0;
    idle = 0;
    i = 0;
    @(posedge mclk_i);
    rd_ready_i <= 1'b0;
    req_valid_i <= 1'b1;
    req_addr_i <= 24'h000000;
    req_space_i <= 3'h1;
    req_byte_i <= 1'b0;
    cur_space = 3'h1;
    while (idle < 30) begin
      #1 r = req_ready_o;
      @(posedge mclk_i);
      if (r === 1'b1) begin
        taken++;
        idle = 0;
        req_addr_i <= 24'(taken * 2);
      end else begin
        idle++;
      end
    end
    req_valid_i <= 1'b0;
    rd_ready_i <= 1'b1;
    `CHK(taken, 33)
    while (i < taken && idle < 100) begin
      #1;
      if (rd_valid_o === 1'b1) begin
        `CHK(rd_data_o, word_of(24'(i * 2)))
        i++;
      end
      @(posedge mclk_i);
      idle++;
    end
    #1 `CHK({i == taken, rd_valid_o}, 2'h2)
  endtask : fill_drain

  initial begin
    rst_b_i = 1'b0;
    req_valid_i = 1'b0;
    req_addr_i = 24'h000000;
    req_space_i = 3'h1;
    req_byte_i = 1'b0;
    rd_ready_i = 1'b1;
    slow_mode = 1'b0;
    ack_wait = 8'h01;
    cur_space = 3'h1;
    repeat (4) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    walk(24'h00ABCE, 3'h1, 1'b0, 9);
    walk(24'h7FFFFE, 3'h2, 1'b0, 9);
    walk(24'h123456, 3'h5, 1'b0, 9);
    walk(24'h000002, 3'h6, 1'b0, 9);
    walk(24'h0055AA, 3'h7, 1'b0, 9);
    walk(24'h003C10, 3'h1, 1'b1, 9);
    walk(24'h003C11, 3'h5, 1'b1, 9);
    ack_wait = 8'h03;
    walk(24'h001234, 3'h1, 1'b0, 11);
    ack_wait = 8'h05;
    walk(24'h004321, 3'h2, 1'b1, 13);
    ack_wait = 8'h01;
    reserved();
    slow_mode = 1'b1;
    slow(3'h5, {1'b0, word_of(24'h012346)});
    slow(3'h7, 17'h10000);
    slow_mode = 1'b0;
    fill_drain();
    conclude();
  end
endmodule : bus_read_master_bench

// File: bench/bus_slave_model.sv
`timescale 1ns/1ps
module bus_slave_model (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [22:0] word_address_i,
  input wire logic addr_strobe_n_i,
  input wire logic upper_byte_strobe_n_i,
  input wire logic lower_byte_strobe_n_i,
  input wire logic [7:0] ack_wait_i,
  input wire logic slow_mode_i,
  output logic [15:0] data_lines_o,
  output logic xfer_ack_n_o,
  output logic slow_periph_select_in_n_o
);
  logic [7:0] sel_cnt_reg;
  logic [15:0] word_w;
  logic [7:0] cnt_w;
  // fixed pattern per word address, so a wrong lane or address shows
  assign word_w = {word_address_i[7:0] ^ 8'h3C, word_address_i[15:8]};
  assign cnt_w = sel_cnt_reg + 8'h01;
  // selected only while the address strobe is low
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel_cnt_reg <= 8'h00;
      data_lines_o <= 16'h0F0F;
      xfer_ack_n_o <= 1'b1;
      slow_periph_select_in_n_o <= 1'b1;
    end else if (addr_strobe_n_i == 1'b0) begin
      sel_cnt_reg <= cnt_w;
      // only strobed lanes carry data; idle lanes keep toggling
      data_lines_o[15:8] <= upper_byte_strobe_n_i ? ~data_lines_o[15:8]
        : word_w[15:8];
      data_lines_o[7:0] <= lower_byte_strobe_n_i ? ~data_lines_o[7:0]
        : word_w[7:0];
      // ack delay is counted in strobe-low cycles
      xfer_ack_n_o <= slow_mode_i || (cnt_w < ack_wait_i);
      slow_periph_select_in_n_o <= !slow_mode_i;
    end else begin
      // released at once on strobe negation, inside one clock
      sel_cnt_reg <= 8'h00;
      data_lines_o <= ~data_lines_o;
      xfer_ack_n_o <= 1'b1;
      slow_periph_select_in_n_o <= 1'b1;
    end
  end
endmodule : bus_slave_model

// File: design/bus_read_master.sv
// Functional notes
// RL1 - space codes: 001,010,101,110,111 only; 000,011,100 never driven
// RL2 - space code outputs stay valid whenever address strobe is asserted
// RL3 - slow peripheral flags itself; transfer follows enable, not acknowledge
// RL4 - peripheral flag during interrupt acknowledge means autovector, no bus fetch
// RL5 - memory-address-valid asserts only after peripheral flag, synced to enable
// RL6 - strobes, acknowledge, peripheral flags active low; read/write high reads
// RL7 - address, strobes, read/write, codes, valid-address are three-state
// RL8 - byte read: address bit zero picks upper strobe, one picks lower
// RL9 - word reads assert both byte strobes together
// RL10 - state 0: address floats, space code driven, read/write high
// RL11 - state 1: address bus driven
// RL12 - state 2: address strobe and required byte strobes asserted
// RL13 - slave decodes address, drives data and acknowledge together
// RL14 - no control output changes during states 3 and 4
// RL15 - late acknowledge: wait states replace states 5 and 6 (here waits go between S4 and S5; S5 and S6 still run)
// RL16 - data bus captured into holding register at end of state 6
// RL17 - state 7 negates strobes; address, read/write, codes stay valid
// RL18 - slave removes data and acknowledge within one clock of negation
// RL19 - slave stays selected while address strobe is asserted
// RL20 - upper strobe covers data 15..8, lower covers data 7..0
// RL21 - acknowledge seen during read: data latched, cycle terminated
// RL22 - each state is half a clock; waits come in whole-clock pairs
`timescale 1ns/1ps
module bus_read_master #(
  parameter int ADDR_W = 24,
  parameter int FIFO_DEPTH = rdbus_pkg::FIFO_DEPTH
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // read requests from the core
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [2:0] req_space_i,
  input wire logic req_byte_i,
  // read results
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [rdbus_pkg::DATA_W-1:0] rd_data_o,
  output logic rd_autovec_o,
  // bus pins
  output logic [ADDR_W-2:0] word_address_o,
  output logic word_address_oe_o,
  input wire logic [rdbus_pkg::DATA_W-1:0] data_lines_i,
  output logic space_code_bit0_o,
  output logic space_code_bit1_o,
  output logic space_code_bit2_o,
  output logic space_code_oe_o,
  output logic rd_wr_n_o,
  output logic rd_wr_oe_o,
  output logic addr_strobe_n_o,
  output logic addr_strobe_oe_o,
  output logic upper_byte_strobe_n_o,
  output logic upper_byte_strobe_oe_o,
  output logic lower_byte_strobe_n_o,
  output logic lower_byte_strobe_oe_o,
  input wire logic xfer_ack_n_i,
  input wire logic slow_periph_select_in_n_i,
  output logic mem_addr_valid_out_n_o,
  output logic mem_addr_valid_out_oe_o,
  output logic periph_enable_o
);
  rdbus_pkg::bus_state_t state_reg, state_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [2:0] space_reg, space_next;
  logic byte_reg, byte_next;
  logic [rdbus_pkg::DATA_W-1:0] hold_reg, hold_next;
  logic autovec_reg, autovec_next;
  logic slow_seen_reg, slow_seen_next;
  logic wait_ph_reg, wait_ph_next;
  logic [rdbus_pkg::E_CNT_W-1:0] e_cnt_reg, e_cnt_next;
  logic fifo_in_ready, fifo_push;
  logic active, strobes_on, ack_seen, slow_seen;
  logic [rdbus_pkg::DATA_W-1:0] bus_word;

  // active-low sampled pins turned into plain flags
  assign ack_seen = !xfer_ack_n_i; // [RL6]
  assign slow_seen = !slow_periph_select_in_n_i; // [RL6]

  // result buffer; only one cycle is ever in flight, so a free slot
  // at request time guarantees room for its word
  rd_fifo #(
    .WIDTH(rdbus_pkg::WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) rd_fifo_inst (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i({autovec_reg, hold_reg}),
    .out_valid_o(rd_valid_o),
    .out_ready_i(rd_ready_i),
    .out_data_o({rd_autovec_o, rd_data_o})
  );

  assign fifo_push = (state_reg == rdbus_pkg::ST_S7);

  // reserved space codes are refused at the door, never driven
  assign req_ready_o = (state_reg == rdbus_pkg::ST_IDLE) && fifo_in_ready &&
    rdbus_pkg::fc_legal(req_space_i); // [RL1]

  // free-running enable for slow peripherals
  always_comb begin
    e_cnt_next = (e_cnt_reg == rdbus_pkg::E_LAST) ? '0 : e_cnt_reg + 1'b1;
  end

  assign periph_enable_o = (e_cnt_reg >= rdbus_pkg::E_HIGH_START);

  // received byte moved into the low lane; words pass whole
  always_comb begin
    bus_word = data_lines_i;
    if (byte_reg) begin
      if (addr_reg[0]) begin
        bus_word = {8'h00, data_lines_i[7:0]}; // [RL20]
      end else begin
        bus_word = {8'h00, data_lines_i[15:8]}; // [RL20]
      end
    end
  end

  // bus state sequence and per-cycle context
  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    space_next = space_reg;
    byte_next = byte_reg;
    hold_next = hold_reg;
    autovec_next = autovec_reg;
    slow_seen_next = slow_seen_reg;
    wait_ph_next = 1'b0;
    case (state_reg)
      rdbus_pkg::ST_IDLE: begin
        if (req_valid_i && req_ready_o) begin
          addr_next = req_addr_i;
          space_next = req_space_i;
          byte_next = req_byte_i;
          autovec_next = 1'b0;
          slow_seen_next = 1'b0;
          state_next = rdbus_pkg::ST_S0;
        end
      end
      rdbus_pkg::ST_S0: state_next = rdbus_pkg::ST_S1; // [RL22]
      rdbus_pkg::ST_S1: state_next = rdbus_pkg::ST_S2;
      rdbus_pkg::ST_S2: state_next = rdbus_pkg::ST_S3;
      rdbus_pkg::ST_S3: state_next = rdbus_pkg::ST_S4;
      rdbus_pkg::ST_S4, rdbus_pkg::ST_WAIT: begin
        // decision falls at the end of S4 or of each whole wait pair
        if (state_reg == rdbus_pkg::ST_WAIT && !wait_ph_reg) begin
          wait_ph_next = 1'b1; // [RL22]
        end else if (ack_seen) begin
          state_next = rdbus_pkg::ST_S5; // [RL21]
        end else if (slow_seen) begin
          slow_seen_next = 1'b1; // [RL3]
          state_next = rdbus_pkg::ST_VSYNC;
        end else begin
          state_next = rdbus_pkg::ST_WAIT; // [RL15]
        end
      end
      rdbus_pkg::ST_S5: state_next = rdbus_pkg::ST_S6;
      rdbus_pkg::ST_S6: begin
        hold_next = bus_word; // [RL16]
        state_next = rdbus_pkg::ST_S7;
      end
      rdbus_pkg::ST_VSYNC: begin
        // line up with the start of an enable low phase
        if (e_cnt_reg == rdbus_pkg::E_LAST) begin
          state_next = rdbus_pkg::ST_VXFER; // [RL5]
        end
      end
      rdbus_pkg::ST_VXFER: begin
        // transfer completes as enable falls
        if (e_cnt_reg == rdbus_pkg::E_LAST) begin
          if (space_reg == rdbus_pkg::FC_INT_ACK) begin
            hold_next = '0; // [RL4]
            autovec_next = 1'b1; // [RL4]
          end else begin
            hold_next = bus_word; // [RL3]
          end
          state_next = rdbus_pkg::ST_S7;
        end
      end
      rdbus_pkg::ST_S7: state_next = rdbus_pkg::ST_IDLE;
      default: state_next = rdbus_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= rdbus_pkg::ST_IDLE;
      addr_reg <= '0;
      space_reg <= rdbus_pkg::FC_USER_DATA;
      byte_reg <= 1'b0;
      hold_reg <= '0;
      autovec_reg <= 1'b0;
      slow_seen_reg <= 1'b0;
      wait_ph_reg <= 1'b0;
      e_cnt_reg <= rdbus_pkg::E_CNT_RESET;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      space_reg <= space_next;
      byte_reg <= byte_next;
      hold_reg <= hold_next;
      autovec_reg <= autovec_next;
      slow_seen_reg <= slow_seen_next;
      wait_ph_reg <= wait_ph_next;
      e_cnt_reg <= e_cnt_next;
    end
  end

  // pin decode; everything floats while no cycle runs
  assign active = (state_reg != rdbus_pkg::ST_IDLE);
  assign strobes_on = active && (state_reg != rdbus_pkg::ST_S0) &&
    (state_reg != rdbus_pkg::ST_S1) && // [RL14]
    (state_reg != rdbus_pkg::ST_S7); // [RL17]

  assign space_code_oe_o = active; // [RL7] [RL2]
  assign space_code_bit0_o = space_reg[0]; // [RL1]
  assign space_code_bit1_o = space_reg[1];
  assign space_code_bit2_o = space_reg[2];
  // read/write held high from state 0 to the end of state 7
  assign rd_wr_oe_o = active; // [RL10]
  assign rd_wr_n_o = 1'b1; // [RL10]
  // address floats in state 0 and is driven from state 1
  assign word_address_oe_o = active && (state_reg != rdbus_pkg::ST_S0);
  assign word_address_o = addr_reg[ADDR_W-1:1]; // [RL11]
  // strobe pins stay driven through state 7 so the negation is seen
  assign addr_strobe_oe_o = active; // [RL7]
  assign addr_strobe_n_o = !strobes_on; // [RL12]
  assign upper_byte_strobe_oe_o = active;
  assign lower_byte_strobe_oe_o = active;
  assign upper_byte_strobe_n_o = !(strobes_on &&
    (!byte_reg || !addr_reg[0])); // [RL8] [RL9]
  assign lower_byte_strobe_n_o = !(strobes_on &&
    (!byte_reg || addr_reg[0])); // [RL8] [RL9]
  assign mem_addr_valid_out_oe_o = active; // [RL7]
  assign mem_addr_valid_out_n_o = !(state_reg == rdbus_pkg::ST_VXFER);

  // checks on the driven pins
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  AST_FC_LEGAL: assert property ( // [RL1]
    !addr_strobe_n_o |-> rdbus_pkg::fc_legal({space_code_bit2_o,
      space_code_bit1_o, space_code_bit0_o}))
    else $error("reserved space code with strobe asserted");

  AST_FC_HELD: assert property ( // [RL2]
    (!addr_strobe_n_o && $past(!addr_strobe_n_o)) |->
      ($stable(space_code_bit0_o) && $stable(space_code_bit1_o) &&
       $stable(space_code_bit2_o) && space_code_oe_o))
    else $error("space code moved under address strobe");

  AST_VMA_CAUSE: assert property ( // [RL5]
    !mem_addr_valid_out_n_o |-> (slow_seen_reg && !addr_strobe_n_o))
    else $error("valid-address output without peripheral flag");

  AST_VMA_SYNC: assert property ( // [RL5]
    $fell(mem_addr_valid_out_n_o) |-> (e_cnt_reg == '0))
    else $error("valid-address not aligned to enable low phase");

  AST_AUTOVEC: assert property ( // [RL4]
    (state_reg == rdbus_pkg::ST_VXFER && e_cnt_reg == rdbus_pkg::E_LAST &&
     space_reg == rdbus_pkg::FC_INT_ACK) |=> (autovec_reg && hold_reg == '0))
    else $error("interrupt acknowledge did not autovector");

  AST_S0_SHAPE: assert property ( // [RL10]
    (state_reg == rdbus_pkg::ST_S0) |->
      (!word_address_oe_o && space_code_oe_o && rd_wr_n_o && rd_wr_oe_o)
      ##1 (word_address_oe_o && addr_strobe_n_o) ##1 !addr_strobe_n_o)
    else $error("read start sequence wrong");

  AST_ADDR_S1: assert property ( // [RL11]
    (state_reg == rdbus_pkg::ST_S1) |-> word_address_oe_o)
    else $error("address not driven in state 1");

  AST_AS_S2: assert property ( // [RL12]
    $fell(addr_strobe_n_o) |-> (state_reg == rdbus_pkg::ST_S2 &&
      (!upper_byte_strobe_n_o || !lower_byte_strobe_n_o)))
    else $error("strobes not asserted together in state 2");

  AST_BYTE_LANE: assert property ( // [RL8]
    (!addr_strobe_n_o && byte_reg) |->
      (upper_byte_strobe_n_o == addr_reg[0]) &&
      (lower_byte_strobe_n_o == !addr_reg[0]))
    else $error("byte strobe does not follow low address bit");

  AST_WORD_LANES: assert property ( // [RL9]
    (!addr_strobe_n_o && !byte_reg) |->
      (!upper_byte_strobe_n_o && !lower_byte_strobe_n_o))
    else $error("word read missing a byte strobe");

  AST_QUIET_S34: assert property ( // [RL14]
    (state_reg == rdbus_pkg::ST_S2) |=>
      ($stable(addr_strobe_n_o) && $stable(upper_byte_strobe_n_o) &&
       $stable(lower_byte_strobe_n_o)) [*2])
    else $error("control output changed in states 3 or 4");

  AST_WAIT_LATE: assert property ( // [RL15]
    (state_reg == rdbus_pkg::ST_S4 && xfer_ack_n_i &&
     slow_periph_select_in_n_i) |=> (state_reg == rdbus_pkg::ST_WAIT) [*2])
    else $error("late acknowledge did not insert a wait pair");

  AST_ACK_END: assert property ( // [RL21]
    (state_reg == rdbus_pkg::ST_S4 && !xfer_ack_n_i) |=>
      ##2 (addr_strobe_n_o && fifo_push) ##1 !active)
    else $error("acknowledged read did not end in four states");

  AST_LATCH_S6: assert property ( // [RL16]
    (state_reg == rdbus_pkg::ST_S6) |=> (hold_reg == $past(bus_word)))
    else $error("holding register missed state 6 data");

  AST_S7_HOLD: assert property ( // [RL17]
    (state_reg == rdbus_pkg::ST_S7) |->
      (addr_strobe_n_o && upper_byte_strobe_n_o && lower_byte_strobe_n_o &&
       word_address_oe_o && rd_wr_n_o && space_code_oe_o &&
       $stable(word_address_o)))
    else $error("state 7 pin levels wrong");

  AST_QUIET_PINS: assert property ( // [RL14]
    (state_reg == rdbus_pkg::ST_S2) |=>
      ($stable(word_address_o) && $stable(space_code_bit0_o) &&
       $stable(space_code_bit1_o) && $stable(space_code_bit2_o) &&
       rd_wr_n_o && word_address_oe_o) [*2])
    else $error("address or space code moved in states 3 or 4");

  AST_IDLE_FLOAT: assert property ( // [RL7]
    (state_reg == rdbus_pkg::ST_IDLE) |->
      !(word_address_oe_o || space_code_oe_o || rd_wr_oe_o ||
        addr_strobe_oe_o || upper_byte_strobe_oe_o ||
        lower_byte_strobe_oe_o || mem_addr_valid_out_oe_o))
    else $error("bus pin driven while no cycle runs");

  AST_SLOW_ENTRY: assert property ( // [RL3]
    (state_reg == rdbus_pkg::ST_S4 && xfer_ack_n_i &&
     !slow_periph_select_in_n_i) |=> (state_reg == rdbus_pkg::ST_VSYNC &&
      mem_addr_valid_out_n_o))
    else $error("peripheral flag did not start enable-timed transfer");

  // one whole enable period with valid-address low, then released
  localparam int VMA_LAST = rdbus_pkg::E_PERIOD_CYC - 1;

  AST_VMA_SPAN: assert property ( // [RL5]
    $fell(mem_addr_valid_out_n_o) |->
      ##VMA_LAST (!mem_addr_valid_out_n_o && periph_enable_o)
      ##1 mem_addr_valid_out_n_o)
    else $error("valid-address did not span one enable period");

endmodule : bus_read_master

// File: design/rd_fifo.sv
`timescale 1ns/1ps
module rd_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 32
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next;
  logic [AW-1:0] rd_ptr_reg, rd_ptr_next;
  logic [CW-1:0] count_reg, count_next;
  logic out_valid_reg, out_valid_next;
  logic [WIDTH-1:0] out_data_reg, out_data_next;
  logic push, pop;

  // full is honest: the output stage only refills from storage
  assign in_ready_o = (count_reg != CW'(DEPTH));
  assign out_valid_o = out_valid_reg;
  assign out_data_o = out_data_reg;
  assign push = in_valid_i && in_ready_o;
  assign pop = (count_reg != '0) && (!out_valid_reg || out_ready_i);

  // pointer, count and output-stage next values
  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    out_valid_next = out_valid_reg;
    out_data_next = out_data_reg;
    if (push) begin
      wr_ptr_next = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
    end
    if (pop) begin
      rd_ptr_next = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      out_data_next = mem[rd_ptr_reg];
      out_valid_next = 1'b1;
    end else if (out_ready_i) begin
      out_valid_next = 1'b0;
    end
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  // storage write; read data leave through a register
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
      out_valid_reg <= out_valid_next;
      out_data_reg <= out_data_next;
    end
  end

endmodule : rd_fifo

// File: design/rdbus_pkg.sv
package rdbus_pkg;

  // bus states: one mclk cycle per numbered half-clock state
  typedef enum {
    ST_IDLE,
    ST_S0,
    ST_S1,
    ST_S2,
    ST_S3,
    ST_S4,
    ST_WAIT,
    ST_S5,
    ST_S6,
    ST_VSYNC,
    ST_VXFER,
    ST_S7
  } bus_state_t;

  // address-space codes, msb first
  localparam logic [2:0] FC_USER_DATA = 3'h1;
  localparam logic [2:0] FC_USER_PROG = 3'h2;
  localparam logic [2:0] FC_SUPV_DATA = 3'h5;
  localparam logic [2:0] FC_SUPV_PROG = 3'h6;
  localparam logic [2:0] FC_INT_ACK = 3'h7;

  // clock figures
  localparam int MCLK_PERIOD_NS = 20;
  localparam int STATES_PER_CLK = 2;
  // wait states come in pairs of half-clock states
  localparam int WAIT_PAIR = STATES_PER_CLK;

  // peripheral enable: six clocks low, four clocks high
  localparam int E_LOW_CLKS = 6;
  localparam int E_HIGH_CLKS = 4;
  localparam int E_LOW_CYC = E_LOW_CLKS * STATES_PER_CLK;
  localparam int E_PERIOD_CYC = (E_LOW_CLKS + E_HIGH_CLKS) * STATES_PER_CLK;
  localparam int E_CNT_W = $clog2(E_PERIOD_CYC);
  localparam logic [E_CNT_W-1:0] E_LAST = E_CNT_W'(E_PERIOD_CYC - 1);
  localparam logic [E_CNT_W-1:0] E_HIGH_START = E_CNT_W'(E_LOW_CYC);
  localparam logic [E_CNT_W-1:0] E_CNT_RESET = '0;

  // read data word: autovector flag above 16 data bits
  localparam int DATA_W = 16;
  localparam int WORD_W = DATA_W + 1;
  localparam int FIFO_DEPTH = 32;

  // reserved codes are never placed on the bus
  function automatic logic fc_legal(input logic [2:0] fc);
    return (fc == FC_USER_DATA) || (fc == FC_USER_PROG) ||
      (fc == FC_SUPV_DATA) || (fc == FC_SUPV_PROG) ||
      (fc == FC_INT_ACK);
  endfunction : fc_legal

endpackage : rdbus_pkg
